// *** cesu_pkg.sv ***
// Package for the energy/assessment status unit: register map, fields, timing.
// Assumes a single system clock at 200 MHz and an 8-bit register port.
package cesu_pkg;
    localparam int CLK_MHZ = 200;
    localparam int ATOM_US = 128;
    localparam int ATOM_CYC = ATOM_US * CLK_MHZ;
    localparam int SLOT_US = 32;
    localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam logic [5:0] ADDR_OPSTAT = 6'h02;
    localparam logic [5:0] ADDR_ACCTL1 = 6'h2F;
    localparam logic [5:0] ADDR_ACCTL2 = 6'h30;
    localparam logic [5:0] ADDR_ESCTL = 6'h31;
    localparam logic [5:0] ADDR_MEAN = 6'h32;
    localparam logic [5:0] ADDR_PEAK = 6'h33;
    localparam logic [5:0] ETHR_RST = 6'h0C;
    localparam logic [3:0] CARRIER_SENSE_THRESHOLD_RST = 4'h0;
    localparam logic [1:0] ALEN_RST = 2'h1;
    localparam logic [1:0] AMETH_RST = 2'h1;
    localparam logic [3:0] SLEN_RST = 4'hE;
    localparam logic [1:0] M_OR = 2'h0;
    localparam logic [1:0] M_CS = 2'h1;
    localparam logic [1:0] M_ED = 2'h2;
    localparam logic [1:0] M_AND = 2'h3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef struct packed {
        logic [3:0] carrier_sense_threshold;
        logic [1:0] assess_duration;
        logic [1:0] assess_method;
    } cesu_ctl2_t;
    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } cesu_reg_req_t;
    typedef enum logic [2:0] {
        MAC_IDLE = 3'h0, MAC_BACKOFF = 3'h1, MAC_CCA = 3'h2, MAC_TX = 3'h3,
        MAC_WAIT_ACK = 3'h4, MAC_LISTEN = 3'h5, MAC_RX_PKT = 3'h6, MAC_TX_ACK = 3'h7
    } cesu_mac_t;
    typedef enum logic [2:0] {
        RF_XTAL = 3'h0, RF_SYNTH = 3'h1, RF_RX = 3'h2, RF_TX = 3'h3,
        RF_CAL = 3'h4, RF_SYNTH_EXT = 3'h5, RF_RX_LNA = 3'h6, RF_TX_PA = 3'h7
    } cesu_rf_t;
endpackage : cesu_pkg

// *** cesu_interval_avg.sv ***
// Averages RSSI samples over one atomic interval and pulses the result.
// Assumes one RSSI sample per clock while enabled.
`timescale 1ns/100ps
module cesu_interval_avg
    import cesu_pkg::*;
#(
    parameter int N_CYC = ATOM_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [7:0] rssi,
    output logic done,
    output logic [7:0] avg
);
    localparam int CW = $clog2(N_CYC + 1);
    localparam int SW = CW + 8;
    logic [CW-1:0] cnt_ff;
    logic [SW-1:0] sum_ff;
    logic last;
    assign last = run && (cnt_ff == CW'(N_CYC - 1));
    // Each interval is atomic: restart whenever run drops
    always_ff @(posedge clk) begin
        if (!rst_b || !run || last) begin
            cnt_ff <= '0;
            sum_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
            sum_ff <= sum_ff + SW'(rssi);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done <= 1'b0;
            avg <= BYTE_ZERO;
        end else begin
            done <= last;
            if (last) begin
                avg <= 8'((sum_ff + SW'(rssi)) / SW'(N_CYC));
            end
        end
    end
endmodule : cesu_interval_avg

// *** cesu_status_mux.sv ***
// Forms the operation status byte and the three general-purpose pin outputs.
// Assumes the MAC and radio state codes are registered upstream.
`timescale 1ns/100ps
module cesu_status_mux
    import cesu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input cesu_mac_t mac_state,
    input cesu_rf_t radio_state,
    input wire logic rx_buffer_full,
    input wire logic pin_config,
    output logic [7:0] operation_status,
    output logic [2:0] gpio_out
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            operation_status <= BYTE_ZERO;
            gpio_out <= 3'h0;
        end else begin
            // Top bit reserved, bit 3 between MAC and radio state mirrors buffer-full
            operation_status <= {1'b0, mac_state, rx_buffer_full, radio_state};
            gpio_out <= pin_config ? radio_state : mac_state;
        end
    end
endmodule : cesu_status_mux

// *** cesu_unit.sv ***
// Energy detect, clear channel assessment and operation status unit.
// Assumes synchronous register port, RSSI and carrier-sense inputs per clock.
`timescale 1ns/100ps
module cesu_unit
    import cesu_pkg::*;
#(
    parameter int ATOM_N = ATOM_CYC,
    parameter int SLOT_N = SLOT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input cesu_reg_req_t reg_req,
    input wire logic reg_en,
    output logic [7:0] reg_rdata,
    input wire logic spi_active,
    input wire logic spi_shift,
    output logic spi_sdo,
    input wire logic [7:0] rssi,
    input wire logic carrier_detect,
    input wire logic [3:0] carrier_level,
    input wire logic seq_cca_req,
    input wire logic seq_csma_en,
    input wire logic transmit_start,
    input wire logic receive_enable,
    input cesu_mac_t mac_state,
    input cesu_rf_t radio_state,
    input wire logic rx_buffer_full,
    input wire logic pin_config,
    output logic seq_cca_done,
    output logic measurement_done_irq,
    output logic rx_keep_active,
    output logic [2:0] gpio_out
);
    typedef enum logic [1:0] {S_IDLE, S_CCA, S_SCAN} cesu_st_t;
    cesu_st_t st_ff;
    logic medium_busy_flag_ff;
    logic assess_start_ff;
    logic [5:0] energy_threshold_ff;
    cesu_ctl2_t ctl2_ff;
    logic energy_sampling_select_ff;
    logic scan_start_ff;
    logic [3:0] scan_length_ff;
    logic [7:0] energy_mean_ff;
    logic [7:0] energy_peak_ff;
    logic [7:0] status_byte;
    logic [7:0] sdo_sr_ff;
    logic [15:0] win_cnt_ff;
    logic [7:0] iv_cnt_ff;
    logic [15:0] sum_ff;
    logic [7:0] peak_run_ff;
    logic cs_seen_ff;
    logic seq_run_ff;
    logic iv_done;
    logic [7:0] iv_avg;
    logic cca_last;
    logic scan_last;
    logic wr;
    logic busy_now;
    logic [7:0] cca_mean;

    function automatic logic [15:0] cca_slots(input logic [1:0] n);
        return 16'(16'h1 << n);
    endfunction : cca_slots

    function automatic logic energy_over(input logic [7:0] mean, input logic [5:0] thr);
        return mean[7:2] > thr;
    endfunction : energy_over

    function automatic logic [7:0] byte_max(input logic [7:0] a, input logic [7:0] b);
        return (a > b) ? a : b;
    endfunction : byte_max

    assign wr = reg_en && reg_req.wr;

    cesu_interval_avg #(.N_CYC(ATOM_N)) u_avg (
        .clk(clk),
        .rst_b(rst_b),
        .run(st_ff == S_SCAN),
        .rssi(rssi),
        .done(iv_done),
        .avg(iv_avg)
    );

    cesu_status_mux u_mux (
        .clk(clk),
        .rst_b(rst_b),
        .mac_state(mac_state),
        .radio_state(radio_state),
        .rx_buffer_full(rx_buffer_full),
        .pin_config(pin_config),
        .operation_status(status_byte),
        .gpio_out(gpio_out)
    );

    // Assessment window: slot counter in units of 32 us
    assign cca_last = (st_ff == S_CCA) && (win_cnt_ff == 16'(SLOT_N - 1))
        && (iv_cnt_ff == 8'(cca_slots(ctl2_ff.assess_duration) - 16'h1));
    // Scan: one atomic interval in peak mode, else (M+1)*8 intervals
    assign scan_last = iv_done && (energy_sampling_select_ff
        || (iv_cnt_ff == 8'({scan_length_ff, 3'h7})));
    // Peak sample of the window stands in for its mean energy
    assign cca_mean = byte_max(sum_ff[7:0], rssi);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff <= S_IDLE;
            seq_run_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                S_IDLE: begin
                    if (seq_csma_en && transmit_start && seq_cca_req) begin
                        st_ff <= S_CCA;
                        seq_run_ff <= 1'b1;
                    end else if (assess_start_ff) begin
                        st_ff <= S_CCA;
                        seq_run_ff <= 1'b0;
                    end else if (scan_start_ff && receive_enable) begin
                        st_ff <= S_SCAN;
                    end
                end
                S_CCA: if (cca_last) st_ff <= S_IDLE;
                S_SCAN: begin
                    if (scan_last || !scan_start_ff || !receive_enable) st_ff <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    // Window counters
    always_ff @(posedge clk) begin
        if (!rst_b || st_ff == S_IDLE) begin
            win_cnt_ff <= '0;
            iv_cnt_ff <= '0;
        end else if (st_ff == S_CCA) begin
            if (win_cnt_ff == 16'(SLOT_N - 1)) begin
                win_cnt_ff <= '0;
                iv_cnt_ff <= iv_cnt_ff + 8'h1;
            end else begin
                win_cnt_ff <= win_cnt_ff + 16'h1;
            end
        end else if (iv_done) begin
            iv_cnt_ff <= iv_cnt_ff + 8'h1;
        end
    end

    // Running peak in the assessment window, running peak/sum in scan
    always_ff @(posedge clk) begin
        if (!rst_b || st_ff == S_IDLE) begin
            sum_ff <= '0;
            peak_run_ff <= BYTE_ZERO;
            cs_seen_ff <= 1'b0;
        end else if (st_ff == S_CCA) begin
            if (win_cnt_ff == 16'h0 && iv_cnt_ff == 8'h0) sum_ff <= 16'(rssi);
            else if (rssi > sum_ff[7:0]) sum_ff <= 16'(rssi);
            if (carrier_detect && carrier_level >= ctl2_ff.carrier_sense_threshold) begin
                cs_seen_ff <= 1'b1;
            end
        end else if (iv_done) begin
            sum_ff <= sum_ff + 16'(iv_avg);
            peak_run_ff <= byte_max(peak_run_ff, iv_avg);
        end
    end

    always_comb begin
        unique case (ctl2_ff.assess_method)
            M_ED: busy_now = energy_over(cca_mean, energy_threshold_ff);
            M_CS: busy_now = cs_seen_ff;
            M_AND: busy_now = cs_seen_ff && energy_over(cca_mean, energy_threshold_ff);
            M_OR: busy_now = cs_seen_ff || energy_over(cca_mean, energy_threshold_ff);
        endcase
    end

    // Results and busy flag
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            energy_mean_ff <= BYTE_ZERO;
            energy_peak_ff <= BYTE_ZERO;
            medium_busy_flag_ff <= 1'b0;
        end else if (cca_last) begin
            medium_busy_flag_ff <= busy_now;
            if (ctl2_ff.assess_method != M_CS) energy_mean_ff <= cca_mean;
        end else if (st_ff == S_SCAN && scan_last) begin
            if (energy_sampling_select_ff) begin
                energy_peak_ff <= iv_avg;
            end else begin
                // Sum of (M+1)*8 interval averages: divide by 8, then by M+1
                energy_mean_ff <= 8'(((sum_ff + 16'(iv_avg)) >> 3)
                    / (16'(scan_length_ff) + 16'h1));
                energy_peak_ff <= byte_max(iv_avg, peak_run_ff);
            end
        end
    end

    // Control registers; hardware clear of start bits wins over a write
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            assess_start_ff <= 1'b0;
            energy_threshold_ff <= ETHR_RST;
            ctl2_ff <= '{CARRIER_SENSE_THRESHOLD_RST, ALEN_RST, AMETH_RST};
            energy_sampling_select_ff <= 1'b0;
            scan_start_ff <= 1'b0;
            scan_length_ff <= SLEN_RST;
        end else begin
            if (wr && reg_req.addr == ADDR_ACCTL1) begin
                assess_start_ff <= reg_req.wdata[6];
                energy_threshold_ff <= reg_req.wdata[5:0];
            end
            if (wr && reg_req.addr == ADDR_ACCTL2) ctl2_ff <= reg_req.wdata;
            if (wr && reg_req.addr == ADDR_ESCTL) begin
                energy_sampling_select_ff <= reg_req.wdata[5];
                scan_start_ff <= reg_req.wdata[4];
                scan_length_ff <= reg_req.wdata[3:0];
            end
            if (cca_last && !seq_run_ff) assess_start_ff <= 1'b0;
            if (st_ff == S_SCAN && scan_last) scan_start_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            measurement_done_irq <= 1'b0;
            seq_cca_done <= 1'b0;
        end else begin
            measurement_done_irq <= cca_last && !seq_run_ff;
            seq_cca_done <= cca_last && seq_run_ff;
        end
    end

    // Reception stays enabled during a software assessment
    assign rx_keep_active = (st_ff == S_CCA) && !seq_run_ff && receive_enable;

    always_comb begin
        unique case (reg_req.addr)
            ADDR_OPSTAT: reg_rdata = status_byte;
            ADDR_ACCTL1: reg_rdata = {medium_busy_flag_ff, assess_start_ff, energy_threshold_ff};
            ADDR_ACCTL2: reg_rdata = ctl2_ff;
            ADDR_ESCTL: reg_rdata = {2'h0, energy_sampling_select_ff, scan_start_ff,
                scan_length_ff};
            ADDR_MEAN: reg_rdata = energy_mean_ff;
            ADDR_PEAK: reg_rdata = energy_peak_ff;
            default: reg_rdata = BYTE_ZERO;
        endcase
    end

    // Status byte loaded at transaction start, shifted MSB first
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdo_sr_ff <= BYTE_ZERO;
        end else if (!spi_active) begin
            sdo_sr_ff <= status_byte;
        end else if (spi_shift) begin
            sdo_sr_ff <= {sdo_sr_ff[6:0], 1'b0};
        end
    end
    assign spi_sdo = sdo_sr_ff[7];

    sequence start_seen;
        st_ff == S_IDLE && assess_start_ff && !(seq_csma_en && transmit_start && seq_cca_req);
    endsequence

    start_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        cca_last && !seq_run_ff |=> !assess_start_ff && measurement_done_irq)
        else $error("start bit not cleared with done");
    start_enter_a: assert property (@(posedge clk) disable iff (!rst_b)
        start_seen |=> st_ff == S_CCA)
        else $error("software start ignored");
    busy_update_a: assert property (@(posedge clk) disable iff (!rst_b)
        cca_last |=> medium_busy_flag_ff == $past(busy_now))
        else $error("busy flag not latched");
    cs_mean_a: assert property (@(posedge clk) disable iff (!rst_b)
        cca_last && ctl2_ff.assess_method == M_CS |=> $stable(energy_mean_ff))
        else $error("mean changed in carrier mode");
    ed_cmp_a: assert property (@(posedge clk) disable iff (!rst_b)
        cca_last && ctl2_ff.assess_method == M_ED
        |=> medium_busy_flag_ff == ($past(cca_mean[7:2]) > $past(energy_threshold_ff)))
        else $error("energy compare wrong");
    and_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        ctl2_ff.assess_method == M_AND && !cs_seen_ff |-> !busy_now)
        else $error("and mode busy without carrier");
    sdo_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        !spi_active ##1 spi_active |-> spi_sdo == $past(status_byte[7]))
        else $error("status byte not on sdo");
    status_top_a: assert property (@(posedge clk) disable iff (!rst_b)
        status_byte[7] == 1'b0 ##1 1'b1 |-> status_byte[3] == $past(rx_buffer_full))
        else $error("buffer full not mirrored");

    sequence scan_finish;
        st_ff == S_SCAN && scan_last;
    endsequence

    sequence scan_peak_end;
        st_ff == S_SCAN && scan_last && energy_sampling_select_ff;
    endsequence

    // Cycles spent in the assessment window, for the length check
    logic [15:0] cca_age_ff;
    always_ff @(posedge clk) begin
        if (!rst_b || st_ff != S_CCA) begin
            cca_age_ff <= '0;
        end else begin
            cca_age_ff <= cca_age_ff + 16'h1;
        end
    end

    sdo_fill_a: assert property (@(posedge clk) disable iff (!rst_b)
        !spi_active |=> sdo_sr_ff == $past(status_byte))
        else $error("status byte not loaded");
    sdo_shift_a: assert property (@(posedge clk) disable iff (!rst_b)
        spi_active && spi_shift |=> sdo_sr_ff == {$past(sdo_sr_ff[6:0]), 1'b0})
        else $error("status byte not shifted");
    seq_done_a: assert property (@(posedge clk) disable iff (!rst_b)
        cca_last && seq_run_ff |=> seq_cca_done && !measurement_done_irq)
        else $error("sequencer done wrong");
    cca_len_a: assert property (@(posedge clk) disable iff (!rst_b)
        cca_last |-> 32'(cca_age_ff) + 1 == (SLOT_N << ctl2_ff.assess_duration))
        else $error("assessment length wrong");
    irq_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        measurement_done_irq |=> !measurement_done_irq)
        else $error("done flag not a pulse");
    scan_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        scan_finish |=> !scan_start_ff && st_ff == S_IDLE)
        else $error("scan start not cleared");
    peak_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
        scan_peak_end |=> energy_peak_ff == $past(iv_avg))
        else $error("peak not stored");
    busy_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !cca_last |=> $stable(medium_busy_flag_ff))
        else $error("busy flag changed outside assessment");
    gpio_radio_a: assert property (@(posedge clk) disable iff (!rst_b)
        pin_config |=> gpio_out == $past(radio_state))
        else $error("pins not radio state");
    gpio_mac_a: assert property (@(posedge clk) disable iff (!rst_b)
        !pin_config |=> gpio_out == $past(mac_state))
        else $error("pins not mac state");
endmodule : cesu_unit

// *** cesu_host_model.sv ***
// Host side of the serial port: frames one transfer and collects the status byte.
// Assumes the bench clock and a unit that presents the status MSB first.
`timescale 1ns/100ps
module cesu_host_model (
    input wire logic clk,
    input wire logic spi_sdo,
    output logic spi_active,
    output logic spi_shift
);
    initial begin
        spi_active = 1'b0;
        spi_shift = 1'b0;
    end

    // Read-only use of the status byte; nothing is ever written back
    task automatic shift_status(output logic [7:0] bits_seen);
        bits_seen = 8'h00;
        @(posedge clk);
        spi_active <= 1'b1;
        for (int b = 7; b >= 0; b--) begin
            @(posedge clk);
            #1 bits_seen[b] = spi_sdo;
            @(posedge clk);
            spi_shift <= 1'b1;
            @(posedge clk);
            spi_shift <= 1'b0;
        end
        spi_active <= 1'b0;
    endtask : shift_status
endmodule : cesu_host_model

// *** cesu_unit_tb.sv ***
// Self-checking bench for the energy detect and assessment unit.
// Assumes cesu_host_model on the serial side and shortened interval counts.
`timescale 1ns/100ps
module cesu_unit_tb;
    import cesu_pkg::*;
    localparam int ATOM_T = 8;
    localparam int SLOT_T = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    cesu_reg_req_t reg_req = '0;
    logic reg_en = 1'b0;
    logic [7:0] reg_rdata;
    logic spi_active;
    logic spi_shift;
    logic spi_sdo;
    logic [7:0] rssi = 8'h00;
    logic carrier_detect = 1'b0;
    logic [3:0] carrier_level = 4'h0;
    logic seq_cca_req = 1'b0;
    logic seq_csma_en = 1'b0;
    logic transmit_start = 1'b0;
    logic receive_enable = 1'b1;
    cesu_mac_t mac_state = MAC_IDLE;
    cesu_rf_t radio_state = RF_XTAL;
    logic rx_buffer_full = 1'b0;
    logic pin_config = 1'b0;
    logic seq_cca_done;
    logic measurement_done_irq;
    logic rx_keep_active;
    logic [2:0] gpio_out;
    int err_total = 0;
    int total_checks = 0;
    int n;
    logic [7:0] rd;
    logic [7:0] exp_st;
    // Method, RSSI, {carrier, busy}, expected mean after the assessment
    logic [31:0] tbl [8] = '{32'h0234_0134, 32'h0230_1030, 32'h01FC_1130, 32'h01FC_0030,
        32'h0334_1134, 32'h0330_1030, 32'h03FC_00FC, 32'h0034_0134};

    always #2.5 clk = ~clk;

    cesu_unit #(.ATOM_N(ATOM_T), .SLOT_N(SLOT_T)) u_dut (
        .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_en(reg_en),
        .reg_rdata(reg_rdata), .spi_active(spi_active), .spi_shift(spi_shift),
        .spi_sdo(spi_sdo), .rssi(rssi), .carrier_detect(carrier_detect),
        .carrier_level(carrier_level), .seq_cca_req(seq_cca_req),
        .seq_csma_en(seq_csma_en), .transmit_start(transmit_start),
        .receive_enable(receive_enable), .mac_state(mac_state),
        .radio_state(radio_state), .rx_buffer_full(rx_buffer_full),
        .pin_config(pin_config), .seq_cca_done(seq_cca_done),
        .measurement_done_irq(measurement_done_irq),
        .rx_keep_active(rx_keep_active), .gpio_out(gpio_out)
    );

    cesu_host_model u_host (
        .clk(clk), .spi_sdo(spi_sdo), .spi_active(spi_active), .spi_shift(spi_shift)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, addr: a, wdata: d};
        reg_en <= 1'b1;
        @(posedge clk);
        reg_en <= 1'b0;
        reg_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
        #1 d = reg_rdata;
    endtask : reg_rd

    task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] v;
        reg_rd(a, v);
        chk(what, v, exp);
    endtask : rd_chk

    // Waits for the software done pulse (sel 0) or the sequencer one (sel 1)
    task automatic wait_for(input bit sel, output int cnt);
        for (cnt = 1; cnt <= 2000; cnt++) begin
            @(posedge clk);
            #1;
            if ((sel ? seq_cca_done : measurement_done_irq) === 1'b1) return;
        end
        chk("done pulse", 8'h00, 8'h01);
        close_out();
    endtask : wait_for

    // Polls the scan start bit until the unit clears it
    task automatic scan_wait();
        logic [7:0] s;
        for (int k = 0; k < 2000; k++) begin
            reg_rd(ADDR_ESCTL, s);
            if (s[4] === 1'b0) return;
        end
        chk("scan end", s, 8'h00);
        close_out();
    endtask : scan_wait

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk("ctl1 rst", ADDR_ACCTL1, 8'h0C);
        rd_chk("ctl2 rst", ADDR_ACCTL2, 8'h05);
        rd_chk("scan rst", ADDR_ESCTL, 8'h0E);
        rd_chk("mean rst", ADDR_MEAN, 8'h00);
        rd_chk("peak rst", ADDR_PEAK, 8'h00);
        rd_chk("status rst", ADDR_OPSTAT, 8'h00);
        rd_chk("unmapped", 6'h3F, 8'h00);
        reg_wr(ADDR_MEAN, 8'hFF);
        rd_chk("mean ro", ADDR_MEAN, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rssi <= tbl[i][23:16];
            carrier_detect <= tbl[i][12];
            carrier_level <= {4{tbl[i][12]}};
            reg_wr(ADDR_ACCTL2, {4'h0, 2'(i % 4), tbl[i][25:24]});
            reg_wr(ADDR_ACCTL1, 8'h4C);
            @(posedge clk);
            #1;
            chk("keep rx", {7'h00, rx_keep_active}, 8'h01);
            wait_for(1'b0, n);
            chk("window lo", {7'h00, n + 1 >= (SLOT_T << (i % 4))}, 8'h01);
            chk("window hi", {7'h00, n + 1 <= (SLOT_T << (i % 4)) + 3}, 8'h01);
            rd_chk("busy", ADDR_ACCTL1, {tbl[i][8], 7'h0C});
            rd_chk("mean", ADDR_MEAN, tbl[i][7:0]);
        end
        $display("test assessment modes done");
        @(posedge clk);
        rssi <= 8'h20;
        reg_wr(ADDR_ACCTL2, {4'h0, 2'h0, M_ED});
        @(posedge clk);
        seq_cca_req <= 1'b1;
        seq_csma_en <= 1'b1;
        transmit_start <= 1'b1;
        @(posedge clk);
        seq_cca_req <= 1'b0;
        #1;
        chk("keep rx seq", {7'h00, rx_keep_active}, 8'h00);
        wait_for(1'b1, n);
        chk("seq window", n[7:0], 8'(SLOT_T));
        @(posedge clk);
        seq_csma_en <= 1'b0;
        transmit_start <= 1'b0;
        rd_chk("seq busy", ADDR_ACCTL1, 8'h0C);
        rd_chk("seq mean", ADDR_MEAN, 8'h20);
        $display("test sequencer done");
        @(posedge clk);
        rssi <= 8'h5A;
        reg_wr(ADDR_ESCTL, 8'h30);
        scan_wait();
        rd_chk("peak", ADDR_PEAK, 8'h5A);
        @(posedge clk);
        rssi <= 8'h44;
        reg_wr(ADDR_ESCTL, 8'h10);
        scan_wait();
        rd_chk("scan mean", ADDR_MEAN, 8'h44);
        rd_chk("scan peak", ADDR_PEAK, 8'h44);
        @(posedge clk);
        rssi <= 8'h66;
        reg_wr(ADDR_ESCTL, 8'h1F);
        scan_wait();
        rd_chk("long mean", ADDR_MEAN, 8'h66);
        $display("test energy scan done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            mac_state <= cesu_mac_t'(i[2:0]);
            radio_state <= cesu_rf_t'(~i[2:0]);
            rx_buffer_full <= i[0];
            pin_config <= i[1];
            repeat (2) @(posedge clk);
            exp_st = {1'b0, i[2:0], i[0], ~i[2:0]};
            rd_chk("status", ADDR_OPSTAT, exp_st);
            chk("pins", {5'h00, gpio_out}, {5'h00, i[1] ? ~i[2:0] : i[2:0]});
            u_host.shift_status(rd);
            chk("sdo", rd, exp_st);
        end
        $display("test status done");
        close_out();
    end
endmodule : cesu_unit_tb
